// *** inc/dma_status_map.svh ***
// Register offsets, field positions and reset values of the DMA status block
`ifndef DMA_STATUS_MAP_SVH
`define DMA_STATUS_MAP_SVH
`define OFF_ACTIVITY      12'h10C
`define OFF_IRQ_ENABLE    12'h110
`define OFF_IRQ_RAW       12'h114
`define OFF_IRQ_MASKED    12'h118
`define OFF_IRQ_CLEAR     12'h11C
`define OFF_IN_ERR_DESC   12'h120
`define OFF_IN_OK_DESC    12'h124
`define OFF_IN_CUR_DESC   12'h128
`define OFF_IN_NEXT_DESC  12'h12C
`define OFF_IN_NEXT_BUF   12'h130
`define OFF_OUT_EOF_BUF   12'h134
`define OFF_OUT_EOF_DESC  12'h138
`define OFF_OUT_CUR_DESC  12'h13C
`define OFF_OUT_NEXT_DESC 12'h140
`define OFF_DMA_CONF      12'h144
`define OFF_FIFO_STATUS   12'h148
`define BIT_RX_ACTIVE     0
`define BIT_FIFO_EMPTY    0
`define BIT_FIFO_FULL     1
`define POS_RX_DESC_LSB   2
`define BIT_EOF_MODE      0
`define BIT_SKIP_INVALID  1
`define ADDR_RESET        32'h0000_0000
`define IRQ_RESET         9'h000
`endif

// *** inc/dma_status_pkg.sv ***
// Types shared by the DMA interrupt and descriptor status block
package dma_status_pkg;
  localparam int NUM_IRQ = 9;

  typedef enum logic [3:0] {
    IRQ_TX_TOTAL_EOF   = 4'h0,
    IRQ_TX_EOF         = 4'h1,
    IRQ_TX_DONE        = 4'h2,
    IRQ_RX_FRAME_OK    = 4'h3,
    IRQ_RX_FRAME_ERR   = 4'h4,
    IRQ_RX_DONE        = 4'h5,
    IRQ_RX_DESC_FAULT  = 4'h6,
    IRQ_TX_DESC_FAULT  = 4'h7,
    IRQ_RX_DESC_EXHAUST = 4'h8
  } irq_idx_t;

  typedef enum logic [1:0] {
    ST_SETUP  = 2'b01,
    ST_ACCESS = 2'b10
  } bus_state_t;

  // Events and addresses from the descriptor engine
  typedef struct packed {
    logic        tx_total_eof;
    logic        tx_pushed_all;
    logic        tx_popped_all;
    logic        tx_done;
    logic        rx_frame_ok;
    logic        rx_frame_err;
    logic        rx_done;
    logic        rx_desc_fault;
    logic        tx_desc_fault;
    logic        rx_desc_exhausted;
    logic        rx_packet_invalid;
    logic        rx_active;
    logic        fifo_empty;
    logic        fifo_full;
    logic [31:0] rx_cur_desc;
    logic [31:0] rx_next_desc;
    logic [31:0] rx_next_buf;
    logic [31:0] tx_cur_desc;
    logic [31:0] tx_next_desc;
    logic [31:0] tx_cur_buf;
  } engine_status_t;

  typedef struct packed {
    bus_state_t  bus;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [8:0]  ena;
    logic [8:0]  raw;
    logic        irq;
    logic        eof_mode;
    logic        skip_invalid;
    logic        rx_advance;
    logic [31:0] in_err_desc;
    logic [31:0] in_ok_desc;
    logic [31:0] in_cur_desc;
    logic [31:0] in_next_desc;
    logic [31:0] in_next_buf;
    logic [31:0] out_eof_buf;
    logic [31:0] out_eof_desc;
    logic [31:0] out_cur_desc;
    logic [31:0] out_next_desc;
    logic [2:0]  flags;
  } state_t;
endpackage

// *** rtl/dma_irq_status.sv ***
// APB register block: DMA interrupt sources and descriptor address capture
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "dma_status_map.svh"

// Notes on behaviour
// [R1] Read/write enable bit per nine sources
// [R2] Raw bit sets on event regardless enable
// [R3] Masked status equals raw and enable
// [R4] Writing one clears descriptor-exhausted interrupt
// [R5] Capture inbound descriptor on receive error
// [R6] Record last inbound descriptor on good EOF
// [R7] Report current inbound descriptor continuously
// [R8] Report next inbound descriptor, reset zero
// [R9] Report next inbound buffer, reset zero
// [R10] Capture outbound buffer address on EOF
// [R11] Record last outbound descriptor on EOF
// [R12] Report current outbound descriptor continuously
// [R13] Status bit shows DMA reading data
// [R14] Flag shows receive FIFO empty
// [R15] Flag shows receive FIFO full
// [R16] Expose low bits of inbound descriptor
// [R17] Outbound EOF follows pop or push mode
// [R18] Skip to next descriptor on invalid packet
// [R19] Other sources clear on write one
// [R20] Interrupt output high while masked bit set
// [R21] Reset clears addresses and status bits
module dma_irq_status
  import dma_status_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Descriptor engine
  input  wire engine_status_t    eng,
  output logic                   rx_advance,
  output logic                   tx_eof_mode,
  // Interrupt
  output logic                   irq
);

  // Offsets up to 0x148 need nine address bits
  if (ADDR_W < 9 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must cover the register map");
  end

  state_t s_r;
  state_t s_nxt;
  logic [8:0]  ev;
  logic [8:0]  clr;
  logic [31:0] rd;
  logic        hit;
  logic        wr_take;
  logic        tx_eof_ev;
  logic [11:0] a;

  assign a = 12'(paddr);

  always_comb begin
    // Outbound EOF source picked by mode
    tx_eof_ev = s_r.eof_mode ? eng.tx_popped_all : eng.tx_pushed_all; // R17
    ev = '0;
    ev[IRQ_TX_TOTAL_EOF]    = eng.tx_total_eof;
    ev[IRQ_TX_EOF]          = tx_eof_ev;
    ev[IRQ_TX_DONE]         = eng.tx_done;
    ev[IRQ_RX_FRAME_OK]     = eng.rx_frame_ok;
    ev[IRQ_RX_FRAME_ERR]    = eng.rx_frame_err;
    ev[IRQ_RX_DONE]         = eng.rx_done;
    ev[IRQ_RX_DESC_FAULT]   = eng.rx_desc_fault;
    ev[IRQ_TX_DESC_FAULT]   = eng.tx_desc_fault;
    ev[IRQ_RX_DESC_EXHAUST] = eng.rx_desc_exhausted;

    hit = 1'b1;
    rd  = 32'h0000_0000;
    case (a)
      `OFF_ACTIVITY:      rd[`BIT_RX_ACTIVE] = s_r.flags[2]; // R13
      `OFF_IRQ_ENABLE:    rd[8:0] = s_r.ena;
      `OFF_IRQ_RAW:       rd[8:0] = s_r.raw;
      `OFF_IRQ_MASKED:    rd[8:0] = s_r.raw & s_r.ena; // R3
      `OFF_IRQ_CLEAR:     rd = 32'h0000_0000;
      `OFF_IN_ERR_DESC:   rd = s_r.in_err_desc;
      `OFF_IN_OK_DESC:    rd = s_r.in_ok_desc;
      `OFF_IN_CUR_DESC:   rd = s_r.in_cur_desc;
      `OFF_IN_NEXT_DESC:  rd = s_r.in_next_desc;
      `OFF_IN_NEXT_BUF:   rd = s_r.in_next_buf;
      `OFF_OUT_EOF_BUF:   rd = s_r.out_eof_buf;
      `OFF_OUT_EOF_DESC:  rd = s_r.out_eof_desc;
      `OFF_OUT_CUR_DESC:  rd = s_r.out_cur_desc;
      `OFF_OUT_NEXT_DESC: rd = s_r.out_next_desc;
      `OFF_DMA_CONF: begin
        rd[`BIT_EOF_MODE]     = s_r.eof_mode;
        rd[`BIT_SKIP_INVALID] = s_r.skip_invalid;
      end
      `OFF_FIFO_STATUS: begin
        rd[`BIT_FIFO_EMPTY] = s_r.flags[0]; // R14
        rd[`BIT_FIFO_FULL]  = s_r.flags[1]; // R15
        rd[`POS_RX_DESC_LSB +: 18] = s_r.in_cur_desc[17:0]; // R16
      end
      default: hit = 1'b0;
    endcase

    s_nxt = s_r;
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;
    wr_take = 1'b0;
    case (s_r.bus)
      ST_SETUP: begin
        if (psel && !penable) begin
          s_nxt.bus = ST_ACCESS;
          s_nxt.pready = 1'b1;
          s_nxt.prdata = pwrite ? 32'h0000_0000 : rd;
          s_nxt.pslverr = !hit;
        end
      end
      ST_ACCESS: begin
        // Access phase completes this edge; the write lands here only
        wr_take = psel && penable && pwrite && hit;
        s_nxt.bus = ST_SETUP;
      end
      default: s_nxt.bus = ST_SETUP;
    endcase

    clr = '0;
    if (wr_take && pstrb[0] && pstrb[1]) begin
      case (a)
        `OFF_IRQ_ENABLE: s_nxt.ena = pwdata[8:0]; // R1
        `OFF_IRQ_CLEAR:  clr = pwdata[8:0]; // R4 R19
        `OFF_DMA_CONF: begin
          s_nxt.eof_mode     = pwdata[`BIT_EOF_MODE];
          s_nxt.skip_invalid = pwdata[`BIT_SKIP_INVALID];
        end
        default: clr = '0;
      endcase
    end

    // Set wins over a clear in the same cycle
    s_nxt.raw = (s_r.raw & ~clr) | ev; // R2
    s_nxt.irq = |(s_nxt.raw & s_nxt.ena); // R20

    if (eng.rx_frame_err) s_nxt.in_err_desc = eng.rx_cur_desc; // R5
    if (eng.rx_frame_ok) s_nxt.in_ok_desc = eng.rx_cur_desc; // R6
    s_nxt.in_cur_desc   = eng.rx_cur_desc; // R7
    s_nxt.in_next_desc  = eng.rx_next_desc; // R8
    s_nxt.in_next_buf   = eng.rx_next_buf; // R9
    if (tx_eof_ev) begin
      s_nxt.out_eof_buf  = eng.tx_cur_buf; // R10
      s_nxt.out_eof_desc = eng.tx_cur_desc; // R11
    end
    s_nxt.out_cur_desc  = eng.tx_cur_desc; // R12
    s_nxt.out_next_desc = eng.tx_next_desc;
    s_nxt.flags = {eng.rx_active, eng.fifo_full, eng.fifo_empty};
    s_nxt.rx_advance = s_r.skip_invalid && eng.rx_packet_invalid; // R18
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0; // R21
      s_r.bus <= ST_SETUP;
      s_r.raw <= `IRQ_RESET;
      s_r.in_err_desc <= `ADDR_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pready      = s_r.pready;
  assign prdata      = s_r.prdata;
  assign pslverr     = s_r.pslverr;
  assign irq         = s_r.irq;
  assign rx_advance  = s_r.rx_advance;
  assign tx_eof_mode = s_r.eof_mode;

  sequence clr_write_s;
    s_r.bus == ST_ACCESS && psel && penable && pwrite && a == `OFF_IRQ_CLEAR
      && pstrb[1:0] == 2'b11;
  endsequence

  a_raw_sets_on_event: assert property (@(posedge clk) disable iff (rst) // R2
    eng.rx_done |=> s_r.raw[IRQ_RX_DONE]) else $error("raw bit missed event");

  a_masked_read_value: assert property (@(posedge clk) disable iff (rst) // R3
    (s_r.bus == ST_SETUP && psel && !penable && !pwrite && a == `OFF_IRQ_MASKED)
      |=> prdata[8:0] == ($past(s_r.raw) & $past(s_r.ena)))
    else $error("masked status read wrong");

  a_exhaust_clear_op: assert property (@(posedge clk) disable iff (rst) // R4
    (clr_write_s and (pwdata[8] && !eng.rx_desc_exhausted)) |=> !s_r.raw[8])
    else $error("exhausted interrupt not cleared");

  a_clear_zero_keeps: assert property (@(posedge clk) disable iff (rst) // R19
    (clr_write_s and (!pwdata[0] && s_r.raw[0])) |=> s_r.raw[0])
    else $error("zero write cleared a bit");

  a_err_desc_capture: assert property (@(posedge clk) disable iff (rst) // R5
    eng.rx_frame_err |=> s_r.in_err_desc == $past(eng.rx_cur_desc))
    else $error("error descriptor not captured");

  a_ok_desc_capture: assert property (@(posedge clk) disable iff (rst) // R6
    eng.rx_frame_ok |=> s_r.in_ok_desc == $past(eng.rx_cur_desc))
    else $error("good EOF descriptor not captured");

  a_tx_eof_mode: assert property (@(posedge clk) disable iff (rst) // R17
    (s_r.eof_mode && eng.tx_popped_all) |=> s_r.raw[IRQ_TX_EOF])
    else $error("outbound EOF mode ignored");

  a_tx_eof_buffer: assert property (@(posedge clk) disable iff (rst) // R10
    (!s_r.eof_mode && eng.tx_pushed_all) |=> s_r.out_eof_buf == $past(eng.tx_cur_buf))
    else $error("outbound EOF buffer not captured");

  a_irq_follows_mask: assert property (@(posedge clk) disable iff (rst) // R20
    (|(ev & s_r.ena) && !wr_take) |=> irq) else $error("interrupt output mismatch");

  a_skip_invalid_pkt: assert property (@(posedge clk) disable iff (rst) // R18
    (s_r.skip_invalid && eng.rx_packet_invalid) |=> rx_advance)
    else $error("invalid packet not skipped");

  a_apb_one_wait: assert property (@(posedge clk) disable iff (rst)
    (s_r.bus == ST_SETUP && psel && !penable) |=> pready ##1 !pready)
    else $error("APB answer timing wrong");

  // Bus phases shared by the register checks below
  sequence apb_setup_s;
    s_r.bus == ST_SETUP && psel && !penable;
  endsequence

  sequence apb_write_s;
    s_r.bus == ST_ACCESS && psel && penable && pwrite && pstrb[1:0] == 2'b11;
  endsequence

  // One pair of checks per interrupt source
  for (genvar g = 0; g < NUM_IRQ; g++) begin : g_src
    a_raw_bit_sets: assert property (@(posedge clk) disable iff (rst) // R2
      ev[g] |=> s_r.raw[g])
      else $error("raw bit missed its event");

    a_clear_one_drops: assert property (@(posedge clk) disable iff (rst) // R19
      (apb_write_s and (a == `OFF_IRQ_CLEAR && pwdata[g] && !ev[g])) |=> !s_r.raw[g])
      else $error("clear write left raw bit set");
  end

  a_irq_low_quiet: assert property (@(posedge clk) disable iff (rst) // R20
    ((s_r.raw & s_r.ena) == 9'h000 && ev == 9'h000 && !wr_take)
      |=> !irq)
    else $error("interrupt output high with nothing pending");

  a_enable_write: assert property (@(posedge clk) disable iff (rst) // R1
    (apb_write_s and (a == `OFF_IRQ_ENABLE))
      |=> s_r.ena == 9'($past(pwdata)))
    else $error("enable write lost");

  a_enable_holds: assert property (@(posedge clk) disable iff (rst) // R1
    !wr_take
      |=> $stable(s_r.ena))
    else $error("enable changed without a write");

  a_partial_strobe: assert property (@(posedge clk) disable iff (rst)
    (s_r.bus == ST_ACCESS && psel && penable && pwrite && pstrb[1:0] != 2'b11)
      |=> $stable(s_r.ena) && $stable(s_r.eof_mode))
    else $error("write with partial strobes took effect");

  a_unmapped_error: assert property (@(posedge clk) disable iff (rst)
    (apb_setup_s and !hit)
      |=> pslverr && pready && prdata == 32'h0000_0000)
    else $error("unmapped address not refused");

  a_write_reads_zero: assert property (@(posedge clk) disable iff (rst)
    (apb_setup_s and pwrite)
      |=> prdata == 32'h0000_0000)
    else $error("write returned read data");

  a_pready_only_access: assert property (@(posedge clk) disable iff (rst)
    !(s_r.bus == ST_SETUP && psel && !penable)
      |=> !pready)
    else $error("pready without a setup phase");

  // Sampled reset gates the trackers: the edge that ends reset loads nothing
  a_in_cur_track: assert property (@(posedge clk) disable iff (rst) // R7
    !rst
      |=> s_r.in_cur_desc == $past(eng.rx_cur_desc))
    else $error("current inbound descriptor stale");

  a_in_next_track: assert property (@(posedge clk) disable iff (rst) // R8
    !rst
      |=> s_r.in_next_desc == $past(eng.rx_next_desc))
    else $error("next inbound descriptor stale");

  a_in_buf_track: assert property (@(posedge clk) disable iff (rst) // R9
    !rst
      |=> s_r.in_next_buf == $past(eng.rx_next_buf))
    else $error("next inbound buffer stale");

  a_out_cur_track: assert property (@(posedge clk) disable iff (rst) // R12
    !rst
      |=> s_r.out_cur_desc == $past(eng.tx_cur_desc))
    else $error("current outbound descriptor stale");

  a_out_eof_desc: assert property (@(posedge clk) disable iff (rst) // R11
    tx_eof_ev
      |=> s_r.out_eof_desc == $past(eng.tx_cur_desc))
    else $error("outbound EOF descriptor not captured");

  a_tx_eof_buf_pop: assert property (@(posedge clk) disable iff (rst) // R10
    (s_r.eof_mode && eng.tx_popped_all)
      |=> s_r.out_eof_buf == $past(eng.tx_cur_buf))
    else $error("outbound EOF buffer missed in pop mode");

  a_tx_eof_push: assert property (@(posedge clk) disable iff (rst) // R17
    (!s_r.eof_mode && eng.tx_pushed_all)
      |=> s_r.raw[IRQ_TX_EOF])
    else $error("outbound EOF missed in push mode");

  a_tx_eof_no_push: assert property (@(posedge clk) disable iff (rst) // R17
    (s_r.eof_mode && !eng.tx_popped_all && !s_r.raw[IRQ_TX_EOF])
      |=> !s_r.raw[IRQ_TX_EOF])
    else $error("outbound EOF raised without a pop");

  a_err_desc_holds: assert property (@(posedge clk) disable iff (rst) // R5
    !eng.rx_frame_err
      |=> $stable(s_r.in_err_desc))
    else $error("error descriptor changed without an error");

  a_ok_desc_holds: assert property (@(posedge clk) disable iff (rst) // R6
    !eng.rx_frame_ok
      |=> $stable(s_r.in_ok_desc))
    else $error("good EOF descriptor changed without EOF");

  a_activity_read: assert property (@(posedge clk) disable iff (rst) // R13
    (apb_setup_s and (!pwrite && a == `OFF_ACTIVITY))
      |=> prdata == 32'($past(s_r.flags[2])))
    else $error("activity status read wrong");

  a_fifo_empty_read: assert property (@(posedge clk) disable iff (rst) // R14
    (apb_setup_s and (!pwrite && a == `OFF_FIFO_STATUS))
      |=> prdata[`BIT_FIFO_EMPTY] == $past(s_r.flags[0]))
    else $error("FIFO empty flag read wrong");

  a_fifo_full_read: assert property (@(posedge clk) disable iff (rst) // R15
    (apb_setup_s and (!pwrite && a == `OFF_FIFO_STATUS))
      |=> prdata[`BIT_FIFO_FULL] == $past(s_r.flags[1]))
    else $error("FIFO full flag read wrong");

  a_desc_low_read: assert property (@(posedge clk) disable iff (rst) // R16
    (apb_setup_s and (!pwrite && a == `OFF_FIFO_STATUS))
      |=> prdata[19:2] == $past(s_r.in_cur_desc[17:0]))
    else $error("descriptor low bits read wrong");

  a_no_skip_idle: assert property (@(posedge clk) disable iff (rst) // R18
    !(s_r.skip_invalid && eng.rx_packet_invalid)
      |=> !rx_advance)
    else $error("descriptor skipped without cause");

  a_conf_write: assert property (@(posedge clk) disable iff (rst) // R17
    (apb_write_s and (a == `OFF_DMA_CONF))
      |=> tx_eof_mode == $past(pwdata[`BIT_EOF_MODE]))
    else $error("EOF mode write lost");

  // Looks one edge after a reset edge, when the cleared state is sampled
  a_reset_clears: assert property (@(posedge clk) // R21
    $past(rst) |-> s_r.raw == `IRQ_RESET && s_r.in_err_desc == `ADDR_RESET
      && s_r.out_eof_buf == `ADDR_RESET && !irq)
    else $error("reset left state behind");

endmodule
`default_nettype wire

// *** testbench/test_dma_irq_status.sv ***
// Self-checking bench for the DMA interrupt and descriptor status block
`timescale 1ns/1ns
`default_nettype none
`include "dma_status_map.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module test_dma_irq_status
  import dma_status_pkg::*;
;
  logic           clk;
  logic           rst;
  logic           psel;
  logic           penable;
  logic           pwrite;
  logic [11:0]    paddr;
  logic [31:0]    pwdata;
  logic [3:0]     pstrb;
  logic           pready;
  logic [31:0]    prdata;
  logic           pslverr;
  logic           rx_advance;
  logic           tx_eof_mode;
  logic           irq;
  engine_status_t eng_r;
  logic [31:0]    rd;
  logic           err;
  logic [31:0]    seed;
  logic [31:0]    x [8];
  logic [8:0]     en;
  int             i;
  int             n_errors = 0;
  int             n_checks = 0;
  int             cyc = 0;

  dma_irq_status #(.ADDR_W(12)) dut_u (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .eng(eng_r), .rx_advance(rx_advance),
    .tx_eof_mode(tx_eof_mode), .irq(irq));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task final_report;
    $display("Checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Request stands until pready is sampled high; the answer is taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Outputs launched by the closing edge settle before callers look at them
    @(negedge clk);
  endtask

  task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  task automatic pulse(input int p);
    @(posedge clk);
    eng_r[p] <= 1'b1;
    @(posedge clk);
    eng_r[p] <= 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      final_report;
    end
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    eng_r = '0;
    seed = 32'h0000_013B;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int a = 12'h10C; a <= 12'h148; a += 4) chk_rd(a[11:0], 32'h0);
    `CHK(irq, 1'b0)
    $display("reset values done");
    // First pass keeps the source disabled, second pass enables it
    for (int k = 0; k < 18; k++) begin
      i = k % 9;
      seed = lfsr(seed);
      en = k < 9 ? seed[8:0] & ~(9'h1 << i) : seed[8:0] | (9'h1 << i);
      apb(1'b1, `OFF_IRQ_ENABLE, {23'h0, en});
      chk_rd(`OFF_IRQ_ENABLE, {23'h0, en});
      pulse(i < 2 ? 205 - i : 204 - i);
      chk_rd(`OFF_IRQ_RAW, 32'h1 << i);
      chk_rd(`OFF_IRQ_MASKED, {23'h0, en} & (32'h1 << i));
      `CHK(irq, en[i])
      apb(1'b1, `OFF_IRQ_CLEAR, ~(32'h1 << i));
      chk_rd(`OFF_IRQ_RAW, 32'h1 << i);
      apb(1'b1, `OFF_IRQ_CLEAR, 32'h1 << i);
      chk_rd(`OFF_IRQ_RAW, 32'h0);
      `CHK(irq, 1'b0)
    end
    $display("interrupt sources done");
    for (int j = 0; j < 8; j++) begin
      seed = lfsr(seed);
      x[j] = seed;
    end
    @(posedge clk);
    eng_r.rx_cur_desc <= x[0];
    eng_r.rx_next_desc <= x[3];
    eng_r.rx_next_buf <= x[4];
    eng_r.tx_cur_buf <= x[5];
    eng_r.tx_cur_desc <= x[6];
    eng_r.tx_next_desc <= x[7];
    pulse(200);
    @(posedge clk);
    eng_r.rx_cur_desc <= x[1];
    pulse(201);
    @(posedge clk);
    eng_r.rx_cur_desc <= x[2];
    eng_r.rx_active <= 1'b1;
    eng_r.fifo_empty <= 1'b1;
    pulse(204);
    @(posedge clk);
    eng_r.tx_cur_desc <= ~x[6];
    apb(1'b1, `OFF_IN_ERR_DESC, ~x[0]);
    chk_rd(`OFF_IN_ERR_DESC, x[0]);
    chk_rd(`OFF_IN_OK_DESC, x[1]);
    chk_rd(`OFF_IN_CUR_DESC, x[2]);
    chk_rd(`OFF_IN_NEXT_DESC, x[3]);
    chk_rd(`OFF_IN_NEXT_BUF, x[4]);
    chk_rd(`OFF_OUT_EOF_BUF, x[5]);
    chk_rd(`OFF_OUT_EOF_DESC, x[6]);
    chk_rd(`OFF_OUT_CUR_DESC, ~x[6]);
    chk_rd(`OFF_OUT_NEXT_DESC, x[7]);
    chk_rd(`OFF_IRQ_RAW, 32'h1A);
    chk_rd(`OFF_ACTIVITY, 32'h1);
    chk_rd(`OFF_FIFO_STATUS, {12'h0, x[2][17:0], 2'b01});
    @(posedge clk);
    eng_r.fifo_empty <= 1'b0;
    eng_r.fifo_full <= 1'b1;
    chk_rd(`OFF_FIFO_STATUS, {12'h0, x[2][17:0], 2'b10});
    $display("address capture done");
    apb(1'b1, `OFF_IRQ_CLEAR, 32'h1FF);
    apb(1'b1, `OFF_DMA_CONF, 32'h1);
    `CHK(tx_eof_mode, 1'b1)
    pulse(204);
    chk_rd(`OFF_IRQ_RAW, 32'h0);
    pulse(203);
    chk_rd(`OFF_IRQ_RAW, 32'h2);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, `OFF_DMA_CONF, {30'h0, s[0], 1'b0});
      pulse(195);
      @(negedge clk);
      `CHK(rx_advance, s[0])
      @(negedge clk);
      `CHK(rx_advance, 1'b0)
    end
    // Writes without both low strobes are ignored
    @(posedge clk);
    pstrb <= 4'hC;
    apb(1'b1, `OFF_IRQ_ENABLE, 32'h0000_01FF);
    @(posedge clk);
    pstrb <= 4'hF;
    chk_rd(`OFF_IRQ_ENABLE, {23'h0, en});
    apb(1'b0, 12'h150, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    $display("modes and refusal done");
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    chk_rd(`OFF_IRQ_RAW, 32'h0);
    chk_rd(`OFF_IN_ERR_DESC, 32'h0);
    chk_rd(`OFF_OUT_EOF_BUF, 32'h0);
    $display("second reset done");
    final_report;
  end
endmodule
`default_nettype wire
